// File: logic/debug_bkpt_pkg.sv
package debug_bkpt_pkg;

    localparam int ADDR_W = 16;
    localparam int QUEUE_DEPTH = 2;
    localparam int DATA_W = 16;

    // Place of the force-reset register in the target memory map
    localparam logic [15:0] FORCE_RESET_ADDR = 16'h1801;
    localparam int FORCE_RESET_BIT = 0;
    localparam logic [7:0] FORCE_RESET_READ = 8'h00;

    // Debug status and control field positions
    localparam int CTRL_ENABLE_BDM_BIT = 7;
    localparam int CTRL_BDM_ACTIVE_BIT = 6;
    localparam int CTRL_BKPT_EN_BIT = 5;
    localparam int CTRL_FORCE_TAG_BIT = 4;

    localparam logic CTRL_BIT_RESET = 1'b0;
    localparam logic [15:0] BKPT_ADDR_RESET = 16'h0000;
    localparam logic [15:0] RSP_RESET = 16'h0000;

    // Commands as delivered by the serial link decoder
    typedef enum logic [2:0] {
        CMD_READ_STATUS,
        CMD_WRITE_CONTROL,
        CMD_BREAKPOINT_READ_COMMAND,
        CMD_BREAKPOINT_WRITE_COMMAND,
        CMD_READ_BYTE,
        CMD_WRITE_BYTE
    } debug_cmd_t;

endpackage

// File: logic/bkpt_match_if.sv
`timescale 1ns/100ps
interface bkpt_match_if #(
    parameter int ADDR_WIDTH = 16
);
    logic enable;
    logic forceTagSelect;
    logic [ADDR_WIDTH-1:0] matchAddr;
    logic [ADDR_WIDTH-1:0] busAddr;
    logic busValid;
    logic opcodeFetch;
    logic instrBoundary;
    logic opcodeExec;
    logic backgroundReq;
    logic suppressExec;

    modport ctrl (
        output enable, forceTagSelect, matchAddr, busAddr, busValid,
        output opcodeFetch, instrBoundary, opcodeExec,
        input backgroundReq, suppressExec
    );
    modport matcher (
        input enable, forceTagSelect, matchAddr, busAddr, busValid,
        input opcodeFetch, instrBoundary, opcodeExec,
        output backgroundReq, suppressExec
    );
endinterface

// File: logic/bkpt_match.sv
`timescale 1ns/100ps
module bkpt_match #(
    parameter int ADDR_WIDTH = 16,
    parameter int QUEUE_DEPTH = 2
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    bkpt_match_if.matcher m
);
    import debug_bkpt_pkg::*;

    localparam int CW = $clog2(QUEUE_DEPTH + 1);

    typedef struct packed {
        logic forcePending;
        logic [QUEUE_DEPTH-1:0] tags;
        logic [CW-1:0] count;
    } match_state_t;

    match_state_t st;
    match_state_t next_st;
    logic hit;
    logic headTagged;

    // Refused at elaboration rather than left to misbehave
    if (QUEUE_DEPTH < 1 || ADDR_WIDTH < 1) begin : g_bad_params
        $error("bkpt_match: unsupported parameters");
    end

    always_comb begin
        next_st = st;
        hit = m.enable && m.busValid && (m.busAddr == m.matchAddr);
        headTagged = m.enable && (st.count != '0) && st.tags[0];
        // Retire the oldest queued opcode
        if (m.opcodeExec && st.count != '0) begin
            next_st.tags = st.tags >> 1;
            next_st.count = st.count - CW'(1);
        end
        // A full queue drops the fetch tag; the core never overfills it
        if (m.opcodeFetch && next_st.count < CW'(QUEUE_DEPTH)) begin
            for (int i = 0; i < QUEUE_DEPTH; i++) begin
                if (CW'(i) == next_st.count) begin
                    next_st.tags[i] = hit && !m.forceTagSelect;
                end
            end
            next_st.count = next_st.count + CW'(1);
        end
        // A new match in the boundary cycle survives the boundary
        next_st.forcePending = (st.forcePending && !m.instrBoundary)
            || (hit && m.forceTagSelect);
        if (!m.enable) begin
            next_st.forcePending = 1'b0;
            next_st.tags = '0;
        end
    end

    assign m.suppressExec = m.opcodeExec && headTagged;
    // Enable gates the outputs too, so a pending force dies with it
    assign m.backgroundReq = (m.enable && st.forcePending && m.instrBoundary)
        || (m.opcodeExec && headTagged);

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule

// File: logic/debug_breakpoint_force_reset.sv
`timescale 1ns/100ps
module debug_breakpoint_force_reset
    import debug_bkpt_pkg::*;
#(
    parameter int ADDR_WIDTH = ADDR_W,
    parameter int QUEUE_DEPTH_P = QUEUE_DEPTH
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    // Decoded serial debug commands
    input wire logic cmdValid,
    input wire debug_bkpt_pkg::debug_cmd_t cmdCode,
    input wire logic [15:0] cmdAddr,
    input wire logic [15:0] cmdData,
    output logic rspValid,
    output logic [15:0] rspData,
    // Background mode status from the core
    input wire logic bdmActive,
    // Processor side
    input wire logic [ADDR_WIDTH-1:0] cpuAddr,
    input wire logic cpuBusValid,
    input wire logic cpuOpcodeFetch,
    input wire logic cpuInstrBoundary,
    input wire logic cpuOpcodeExec,
    input wire logic cpuRdEn,
    input wire logic cpuWrEn,
    output logic cpuRdHit,
    output logic [7:0] cpuRdData,
    output logic cpuWrHit,
    // Results
    output logic enterBackground,
    output logic suppressExec,
    output logic forceResetReq
);
    import debug_bkpt_pkg::*;

    typedef struct packed {
        // Debug status and control bits kept by the controller
        logic enableBdm;
        logic bkptEnable;
        logic forceTagSelect;
        // Compare target, reachable from the serial side only
        logic [15:0] breakpointAddressMatch;
        // Answer to the serial host
        logic rspValid;
        logic [15:0] rspData;
        // One-cycle request towards the system reset logic
        logic forceReset;
        // Answer to a processor read of the force-reset address
        logic cpuRdHit;
        logic [7:0] cpuRdData;
    } top_state_t;

    top_state_t st;
    top_state_t next_st;
    logic cmdIsForceReset;

    bkpt_match_if #(.ADDR_WIDTH(ADDR_WIDTH)) matchBus ();

    ////////////////////////////////////////////////////////////////////////
    // Parameter checks, refused at elaboration

    // The breakpoint register is 16 bits, so a wider bus cannot be matched
    if (ADDR_WIDTH < 1 || ADDR_WIDTH > 16) begin : g_bad_addr_width
        $error("debug_breakpoint_force_reset: unsupported address width");
    end

    // Tagging needs at least one queue entry to travel with
    if (QUEUE_DEPTH_P < 1) begin : g_bad_queue_depth
        $error("debug_breakpoint_force_reset: unsupported queue depth");
    end

    ////////////////////////////////////////////////////////////////////////
    // Address decode shared by the serial and the processor paths

    // Decoded in one place so both paths agree on the address
    function automatic logic is_force_reset(input logic [15:0] addr);
        is_force_reset = (addr == FORCE_RESET_ADDR);
    endfunction

    function automatic logic [7:0] status_byte(
        input logic enBdm,
        input logic active,
        input logic bkEn,
        input logic force_tag_select
    );
        logic [7:0] v;
        // Low nibble reports no wait, stop or slow-memory conditions
        v = 8'h00;
        v[CTRL_ENABLE_BDM_BIT] = enBdm;
        v[CTRL_BDM_ACTIVE_BIT] = active;
        v[CTRL_BKPT_EN_BIT] = bkEn;
        v[CTRL_FORCE_TAG_BIT] = force_tag_select;
        status_byte = v;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Serial command handling

    always_comb begin
        // Answers and requests are pulses; stored fields hold by default
        next_st = st;
        next_st.rspValid = 1'b0;
        next_st.forceReset = 1'b0;
        next_st.cpuRdHit = 1'b0;
        next_st.cpuRdData = 8'h00;
        cmdIsForceReset = is_force_reset(cmdAddr);

        if (cmdValid) begin
            unique case (cmdCode)
                CMD_READ_STATUS: begin
                    // Active flag is live from the core, not stored here
                    next_st.rspValid = 1'b1;
                    next_st.rspData = {8'h00, status_byte(st.enableBdm,
                        bdmActive, st.bkptEnable, st.forceTagSelect)};
                end

                CMD_WRITE_CONTROL: begin
                    // Only the three control bits are stored
                    next_st.enableBdm = cmdData[CTRL_ENABLE_BDM_BIT];
                    next_st.bkptEnable = cmdData[CTRL_BKPT_EN_BIT];
                    next_st.forceTagSelect = cmdData[CTRL_FORCE_TAG_BIT];
                end

                CMD_BREAKPOINT_READ_COMMAND: begin
                    next_st.rspValid = 1'b1;
                    next_st.rspData = st.breakpointAddressMatch;
                end

                CMD_BREAKPOINT_WRITE_COMMAND: begin
                    // A load while the core runs applies from the next cycle
                    next_st.breakpointAddressMatch = cmdData;
                end

                CMD_READ_BYTE: begin
                    // Other addresses belong to the memory system
                    if (cmdIsForceReset) begin
                        next_st.rspValid = 1'b1;
                        next_st.rspData = {8'h00, FORCE_RESET_READ};
                    end
                end

                CMD_WRITE_BYTE: begin
                    if (cmdIsForceReset) begin
                        // One-cycle request; the reset it causes clears us
                        next_st.forceReset =
                            cmdData[FORCE_RESET_BIT];
                    end
                end

                // Two codes of the command field are unused
                default: begin
                end
            endcase
        end

        // Processor reads see zeros; processor writes never reach state
        // The read answer follows one cycle later, like any register read
        if (cpuRdEn && is_force_reset(16'(cpuAddr))) begin
            next_st.cpuRdHit = 1'b1;
            next_st.cpuRdData = FORCE_RESET_READ;
        end
    end

    // Seen only so the bus can complete the cycle; it never reaches state
    assign cpuWrHit = cpuWrEn && is_force_reset(16'(cpuAddr));

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            // The host must permit background mode again after any reset
            st.enableBdm <= CTRL_BIT_RESET;
            st.bkptEnable <= CTRL_BIT_RESET;
            st.forceTagSelect <= CTRL_BIT_RESET;
            st.breakpointAddressMatch <= BKPT_ADDR_RESET;
            st.rspValid <= 1'b0;
            st.rspData <= RSP_RESET;
            st.forceReset <= 1'b0;
            st.cpuRdHit <= 1'b0;
            st.cpuRdData <= FORCE_RESET_READ;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Breakpoint comparison

    // Configuration from the debug registers
    assign matchBus.enable = st.bkptEnable;
    assign matchBus.forceTagSelect = st.forceTagSelect;
    assign matchBus.matchAddr = st.breakpointAddressMatch[ADDR_WIDTH-1:0];

    // Live processor bus, compared in the same cycle it is presented
    assign matchBus.busAddr = cpuAddr;
    assign matchBus.busValid = cpuBusValid;
    assign matchBus.opcodeFetch = cpuOpcodeFetch;
    assign matchBus.instrBoundary = cpuInstrBoundary;
    assign matchBus.opcodeExec = cpuOpcodeExec;

    bkpt_match #(
        .ADDR_WIDTH(ADDR_WIDTH),
        .QUEUE_DEPTH(QUEUE_DEPTH_P)
    // The matcher keeps its own tag queue and pending force request
    ) bkpt_match_i (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .m(matchBus.matcher)
    );

    // Background entry is only possible once the host has permitted it
    assign enterBackground = matchBus.backgroundReq && st.enableBdm;
    assign suppressExec = matchBus.suppressExec && st.enableBdm;

    ////////////////////////////////////////////////////////////////////////
    // Registered outputs

    assign rspValid = st.rspValid;
    assign rspData = st.rspData;
    assign forceResetReq = st.forceReset;
    assign cpuRdHit = st.cpuRdHit;
    assign cpuRdData = st.cpuRdData;
endmodule

// File: tb/dbfr_monitor.sv
`timescale 1ns/100ps
module dbfr_monitor
    import debug_bkpt_pkg::*;
#(
    parameter int ADDR_WIDTH = ADDR_W
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic cmdValid,
    input wire debug_bkpt_pkg::debug_cmd_t cmdCode,
    input wire logic [15:0] cmdAddr,
    input wire logic [15:0] cmdData,
    input wire logic rspValid,
    input wire logic [15:0] rspData,
    input wire logic [ADDR_WIDTH-1:0] cpuAddr,
    input wire logic cpuBusValid,
    input wire logic cpuInstrBoundary,
    input wire logic cpuOpcodeExec,
    input wire logic cpuRdEn,
    input wire logic cpuWrEn,
    input wire logic cpuRdHit,
    input wire logic [7:0] cpuRdData,
    input wire logic enterBackground,
    input wire logic suppressExec,
    input wire logic forceResetReq
);
default clocking @(posedge sys_clk); endclocking
default disable iff (!arst_n);
logic [15:0] bkAddr;
logic enBdm, bkEn, force_tag_select, frWr, bkHit;
// Shadow of the debug registers, rebuilt from the command stream
always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
        bkAddr <= 16'h0000;
        {enBdm, bkEn, force_tag_select} <= 3'h0;
    end else if (cmdValid && cmdCode == CMD_BREAKPOINT_WRITE_COMMAND) begin
        bkAddr <= cmdData;
    end else if (cmdValid && cmdCode == CMD_WRITE_CONTROL) begin
        {enBdm, bkEn, force_tag_select} <= {cmdData[7], cmdData[5], cmdData[4]};
    end
end
assign frWr = cmdValid && cmdCode == CMD_WRITE_BYTE
    && cmdAddr == FORCE_RESET_ADDR && cmdData[0];
assign bkHit = bkEn && force_tag_select && enBdm && cpuBusValid && cpuAddr == bkAddr;
////////////////////////////////////////////////////////////////////////
property p_bkRd;
    cmdValid && cmdCode == CMD_BREAKPOINT_READ_COMMAND |=> rspValid && rspData == bkAddr;
endproperty
a_bkRd: assert property (p_bkRd) else $error("breakpoint readback");
property p_stat;
    cmdValid && cmdCode == CMD_READ_STATUS
        |=> rspValid && {rspData[7], rspData[5:4]} == {enBdm, bkEn, force_tag_select};
endproperty
a_stat: assert property (p_stat) else $error("status bits");
property p_rdByte;
    cmdValid && cmdCode == CMD_READ_BYTE && cmdAddr == FORCE_RESET_ADDR
        |=> rspValid && rspData == 16'h0000;
endproperty
a_rdByte: assert property (p_rdByte) else $error("serial read");
property p_frReq;
    frWr |=> forceResetReq;
endproperty
a_frReq: assert property (p_frReq) else $error("no reset request");
property p_frOnly;
    !frWr |=> !forceResetReq;
endproperty
a_frOnly: assert property (p_frOnly) else $error("stray reset");
property p_cpuWr;
    cpuWrEn && !frWr |=> !forceResetReq;
endproperty
a_cpuWr: assert property (p_cpuWr) else $error("user write acted");
property p_cpuRd;
    cpuRdEn && cpuAddr == FORCE_RESET_ADDR |=> cpuRdHit && cpuRdData == 8'h00;
endproperty
a_cpuRd: assert property (p_cpuRd) else $error("user read");
property p_off;
    !bkEn |-> !enterBackground && !suppressExec;
endproperty
a_off: assert property (p_off) else $error("disabled breakpoint hit");
property p_force;
    bkHit ##1 (cpuInstrBoundary && bkEn && enBdm) |-> enterBackground;
endproperty
a_force: assert property (p_force) else $error("force missed");
property p_sup;
    suppressExec |-> enterBackground && cpuOpcodeExec;
endproperty
a_sup: assert property (p_sup) else $error("suppress alone");
c_fr: cover property (forceResetReq);
c_tag: cover property (suppressExec);
c_force: cover property (enterBackground && !suppressExec);
endmodule

// File: tb/debug_host_model.sv
`timescale 1ns/100ps
module debug_host_model
    import debug_bkpt_pkg::*;
(
    input wire logic sys_clk,
    output logic cmdValid,
    output debug_bkpt_pkg::debug_cmd_t cmdCode,
    output logic [15:0] cmdAddr,
    output logic [15:0] cmdData,
    input wire logic rspValid,
    input wire logic [15:0] rspData
);
initial begin
    cmdValid = 1'b0;
    cmdCode = CMD_READ_STATUS;
    cmdAddr = 16'h0000;
    cmdData = 16'h0000;
end
// Registers reached by serial commands only; gap makes a slow host
task automatic send(input debug_cmd_t c, input logic [15:0] a,
    input logic [15:0] d, input int gap, output logic [15:0] r,
    output logic v);
    repeat (gap) @(posedge sys_clk);
    @(posedge sys_clk);
    #1;
    cmdValid = 1'b1;
    cmdCode = c;
    cmdAddr = a;
    cmdData = d;
    @(posedge sys_clk);
    #1;
    cmdValid = 1'b0;
    // Released fields scrambled so nothing relies on stale values
    cmdAddr = ~a;
    cmdData = ~d;
    v = rspValid;
    r = rspData;
endtask
endmodule

// File: tb/tb_debug_breakpoint_force_reset.sv
`timescale 1ns/100ps
module tb_debug_breakpoint_force_reset;
import debug_bkpt_pkg::*;
logic sys_clk = 1'b0;
logic arst_n = 1'b0;
logic cmdValid, rspValid, bdmActive, cpuBusValid, cpuOpcodeFetch;
logic cpuInstrBoundary, cpuOpcodeExec, cpuRdEn, cpuWrEn, cpuRdHit;
logic cpuWrHit, enterBackground, suppressExec, forceResetReq, v;
debug_cmd_t cmdCode;
logic [15:0] cmdAddr, cmdData, rspData, cpuAddr, r;
logic [7:0] cpuRdData;
int err_count = 0;
int checks_done = 0;
always #2 sys_clk = ~sys_clk;
debug_breakpoint_force_reset debug_breakpoint_force_reset_i (.sys_clk,
    .arst_n, .cmdValid, .cmdCode, .cmdAddr, .cmdData, .rspValid, .rspData,
    .bdmActive, .cpuAddr, .cpuBusValid, .cpuOpcodeFetch, .cpuInstrBoundary,
    .cpuOpcodeExec, .cpuRdEn, .cpuWrEn, .cpuRdHit, .cpuRdData, .cpuWrHit,
    .enterBackground, .suppressExec, .forceResetReq);
debug_host_model debug_host_model_i (.sys_clk, .cmdValid, .cmdCode,
    .cmdAddr, .cmdData, .rspValid, .rspData);
////////////////////////////////////////////////////////////////////////
task automatic chk(input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
        err_count++;
        $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
endtask
task automatic chkf(input logic e, input logic g);
    chk({15'h0, e}, {15'h0, g});
endtask
task automatic cmd(input debug_cmd_t c, input logic [15:0] a,
    input logic [15:0] d);
    debug_host_model_i.send(c, a, d, 1, r, v);
endtask
task automatic cpu(input logic [5:0] s, input logic [15:0] a);
    @(posedge sys_clk);
    #1;
    {cpuBusValid, cpuOpcodeFetch, cpuInstrBoundary} = s[5:3];
    {cpuOpcodeExec, cpuRdEn, cpuWrEn} = s[2:0];
    cpuAddr = a;
    #1;
endtask
task automatic t_regs;
    bdmActive = 1'b1;
    cmd(CMD_BREAKPOINT_READ_COMMAND, 16'h0000, 16'h0000);
    chk(16'h0000, r);
    chkf(1'b1, v);
    cmd(CMD_BREAKPOINT_WRITE_COMMAND, 16'h0000, 16'hA55A);
    cmd(CMD_BREAKPOINT_READ_COMMAND, 16'h0000, 16'h0000);
    chk(16'hA55A, r);
    cmd(CMD_WRITE_CONTROL, 16'h0000, 16'h00B0);
    cmd(CMD_READ_STATUS, 16'h0000, 16'h0000);
    chk(16'h00F0, r);
    $display("regs done");
endtask
task automatic t_reset;
    cmd(CMD_WRITE_BYTE, FORCE_RESET_ADDR, 16'h00FE);
    chkf(1'b0, forceResetReq);
    cmd(CMD_WRITE_BYTE, FORCE_RESET_ADDR, 16'h0001);
    chkf(1'b1, forceResetReq);
    cmd(CMD_READ_BYTE, FORCE_RESET_ADDR, 16'h0000);
    chk(16'h0000, r);
    chkf(1'b1, v);
    cmd(CMD_READ_BYTE, 16'h1800, 16'h0000);
    chkf(1'b0, v);
    // Request is honoured by the external system reset
    arst_n = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    arst_n = 1'b1;
    cmd(CMD_BREAKPOINT_READ_COMMAND, 16'h0000, 16'h0000);
    chk(16'h0000, r);
    $display("reset done");
endtask
task automatic t_cpu;
    cpu(6'b000001, FORCE_RESET_ADDR);
    chkf(1'b1, cpuWrHit);
    cpu(6'b000010, FORCE_RESET_ADDR);
    chkf(1'b0, forceResetReq);
    cpu(6'b000000, 16'h0000);
    chk(16'h0000, {7'h00, cpuRdHit, cpuRdData} ^ 16'h0100);
    $display("cpu done");
endtask
task automatic t_bkpt;
    cmd(CMD_BREAKPOINT_WRITE_COMMAND, 16'h0000, 16'h2345);
    cmd(CMD_WRITE_CONTROL, 16'h0000, 16'h00B0);
    bdmActive = 1'b0;
    cpu(6'b100000, 16'h2345);
    cpu(6'b001000, 16'h0000);
    chk(16'h0002, {enterBackground, suppressExec});
    cpu(6'b000000, 16'h0000);
    cmd(CMD_WRITE_CONTROL, 16'h0000, 16'h0090);
    cpu(6'b100000, 16'h2345);
    cpu(6'b001000, 16'h0000);
    chkf(1'b0, enterBackground);
    cpu(6'b000000, 16'h0000);
    cmd(CMD_WRITE_CONTROL, 16'h0000, 16'h00A0);
    cpu(6'b110000, 16'h2345);
    cpu(6'b000100, 16'h0000);
    chk(16'h0003, {enterBackground, suppressExec});
    cpu(6'b000000, 16'h0000);
    $display("breakpoint done");
endtask
task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
        $display("== PASSED ==");
    end else begin
        $display("== FAILED ==");
    end
    $finish;
endtask
initial begin
    bdmActive = 1'b0;
    cpuAddr = 16'h0000;
    {cpuBusValid, cpuOpcodeFetch, cpuInstrBoundary} = 3'h0;
    {cpuOpcodeExec, cpuRdEn, cpuWrEn} = 3'h0;
    repeat (12) @(posedge sys_clk);
    #1;
    arst_n = 1'b1;
    t_regs;
    t_reset;
    t_cpu;
    t_bkpt;
    complete_run;
end
// Tests need about 70 cycles; generous margin before declaring a hang
initial begin
    repeat (3000) @(posedge sys_clk);
    err_count++;
    complete_run;
end
endmodule
bind debug_breakpoint_force_reset dbfr_monitor #(.ADDR_WIDTH(ADDR_WIDTH))
    dbfr_monitor_i (.sys_clk, .arst_n, .cmdValid, .cmdCode, .cmdAddr,
    .cmdData, .rspValid, .rspData, .cpuAddr, .cpuBusValid,
    .cpuInstrBoundary, .cpuOpcodeExec, .cpuRdEn, .cpuWrEn, .cpuRdHit,
    .cpuRdData, .enterBackground, .suppressExec, .forceResetReq);
